// ==== logic/ext_bus_cfg_pkg.sv ====
// Shared constants and types for the external area bus configuration block
`default_nettype none

package ext_bus_cfg_pkg;

   // ==========================================================================
   // Register bus
   localparam int          ADDR_W                 = 8;
   localparam int          DATA_W                 = 32;
   localparam logic [7:0]  OFS_AREA_BUS_WIDTH     = 8'h00;
   localparam logic [7:0]  OFS_AREA_ACCESS_STATES = 8'h04;
   localparam logic [7:0]  OFS_WAIT_UPPER_AREAS   = 8'h08;
   localparam logic [7:0]  OFS_WAIT_LOWER_AREAS   = 8'h0C;
   localparam logic [7:0]  OFS_STATUS             = 8'h10;
   localparam logic [1:0]  RESP_OKAY              = 2'h0;
   localparam logic [1:0]  RESP_SLVERR            = 2'h2;

   // ==========================================================================
   // Reset values
   localparam logic [7:0]  RST_WIDTH_NARROW       = 8'hFF;
   localparam logic [7:0]  RST_WIDTH_WIDE         = 8'h00;
   localparam logic [7:0]  RST_ACCESS_STATES      = 8'hFF;
   localparam logic [7:0]  RST_WAIT               = 8'hFF;
   localparam logic [7:0]  ALL_AREAS_NARROW       = 8'hFF;

   // ==========================================================================
   // Operating mode strap codes (code + 1 is the mode number)
   localparam logic [1:0]  MODE_1                 = 2'h0;
   localparam logic [1:0]  MODE_2                 = 2'h1;
   localparam logic [1:0]  MODE_3                 = 2'h2;
   localparam logic [1:0]  MODE_4                 = 2'h3;

   // ==========================================================================
   // Access timing
   localparam int          WAIT_FIELD_W           = 2;
   localparam logic [2:0]  STATES_TWO             = 3'h2;
   localparam logic [2:0]  STATES_THREE           = 3'h3;
   localparam logic [2:0]  ONCHIP_STATES          = 3'h2;
   localparam logic        ONCHIP_WIDE            = 1'b1;
   localparam logic [1:0]  ONCHIP_WAITS           = 2'h0;

   // ==========================================================================
   // Status register fields
   localparam int          STAT_BUS16_BIT         = 0;
   localparam int          STAT_RUN_BIT           = 1;
   localparam int          STAT_SWSTBY_BIT        = 2;
   localparam int          STAT_MODE_LSB          = 4;

   typedef enum logic [1:0] {
      ST_SYNC0 = 2'b00,
      ST_SYNC1 = 2'b01,
      ST_HOLD  = 2'b10,
      ST_RUN   = 2'b11
   } cfg_state_t;

endpackage

`default_nettype wire

// ==== logic/area_attr_lookup.sv ====
// Per-area attribute selection from the width, access-state and wait registers
`default_nettype none

module area_attr_lookup #(
   parameter int N_AREAS = 8,
   parameter int AREA_W  = 3
) (
   // Register contents
   input  wire logic [N_AREAS-1:0]     width_bits,
   input  wire logic [N_AREAS-1:0]     three_bits,
   input  wire logic [7:0]             wait_upper,
   input  wire logic [7:0]             wait_lower,
   // Selected area
   input  wire logic [AREA_W-1:0]      area,
   output logic                        narrow,
   output logic                        three_state,
   output logic [1:0]                  wait_field
);
   logic [15:0]     wait_packed;
   logic [AREA_W:0] lsb;

   // ==========================================================================
   // Selection
   assign wait_packed = {wait_upper, wait_lower};
   assign lsb         = {area, 1'b0};
   assign narrow      = width_bits[area];
   assign three_state = three_bits[area];
   assign wait_field  = wait_packed[lsb +: 2];

endmodule

`default_nettype wire

// ==== logic/axil_cfg_slave.sv ====
// AXI4-Lite slave front end for the configuration registers
`default_nettype none

module axil_cfg_slave
   import ext_bus_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   nrst,
   // Write channels
   input  wire logic [ADDR_W-1:0]      awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [DATA_W-1:0]      wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   // Read channels
   input  wire logic [ADDR_W-1:0]      araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [DATA_W-1:0]           rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   // Register side
   output logic                        wr_en,
   output logic                        wr_strb,
   output logic [ADDR_W-1:0]           wr_addr,
   output logic [7:0]                  wr_data,
   input  wire logic                   wr_ok,
   input  wire logic [7:0]             rd_word,
   input  wire logic                   rd_ok
);
   logic              aw_held_reg, aw_held_next;
   logic              w_held_reg, w_held_next;
   logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic [7:0]        w_data_reg, w_data_next;
   logic              w_strb_reg, w_strb_next;
   logic              awready_reg, awready_next, wready_reg, wready_next;
   logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic              arready_reg, arready_next;
   logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic              fire;

   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;
   assign wr_addr = aw_addr_reg;
   assign wr_data = w_data_reg;
   assign wr_strb = w_strb_reg;
   // Address and data may arrive in either order; the write happens once both are held
   assign fire    = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_en   = fire && wr_ok;

   // ==========================================================================
   // Channel state
   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next  = w_held_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      if (awvalid && awready_reg) begin
         aw_held_next = 1'b1;
         aw_addr_next = awaddr;
      end
      if (wvalid && wready_reg) begin
         w_held_next = 1'b1;
         w_data_next = wdata[7:0];
         w_strb_next = wstrb[0];
      end
      if (fire) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      if (arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rdata_next  = rd_ok ? {24'h000000, rd_word} : 32'h00000000;
         rresp_next  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
      awready_next = !aw_held_next;
      wready_next  = !w_held_next;
      arready_next = !rvalid_next;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 8'h00;
         w_strb_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'h0;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h00000000;
         rresp_reg   <= 2'h0;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg  <= w_data_next;
         w_strb_reg  <= w_strb_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

endmodule

`default_nettype wire

// ==== logic/external_area_bus_config.sv ====
// Per-area external bus width, access-state and wait-state configuration
//
// Behaviour
// - Each area has a width bit; 0 selects 16-bit, 1 selects 8-bit.
// - All width bits one gives 8-bit bus mode; upper byte only, port 4 free.
// - Any width bit zero gives 16-bit bus mode using all sixteen lines.
// - Modes 1 and 3: reset and hardware standby load width register all ones.
// - Modes 2 and 4: reset and hardware standby load width register all zeros.
// - Software standby keeps all registers; only reset or hardware standby reload.
// - Width bits apply to external areas only; on-chip keeps fixed width.
// - Each area has an access-state bit; 0 two states, 1 three states.
// - Reset and hardware standby set all access-state bits to one.
// - On-chip accesses take a fixed state count, ignoring access-state bits.
// - Two-bit wait field per area adds 0 to 3 waits, three-state areas only.
// - Wait fields packed two bits per area; upper register areas 7-4.
// - Reset and hardware standby set both wait registers to all ones.
// - On-chip accesses ignore the wait fields.

`default_nettype none

module external_area_bus_config
   import ext_bus_cfg_pkg::*;
#(
   parameter int N_AREAS = 8,
   parameter int AREA_W  = 3
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   nrst,

   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0]      awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [DATA_W-1:0]      wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,

   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0]      araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [DATA_W-1:0]           rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,

   // Chip pins and power state
   input  wire logic [1:0]             mode_pins,
   input  wire logic                   hw_standby_n,
   input  wire logic                   sw_standby,

   // External access request from the bus sequencer
   input  wire logic                   ext_start,
   input  wire logic [AREA_W-1:0]      ext_area,
   input  wire logic                   ext_onchip,

   // Attributes of the access just started
   output logic                        cyc_valid,
   output logic                        cyc_wide,
   output logic [2:0]                  cyc_states,
   output logic [1:0]                  cyc_waits,

   // Chip-wide bus mode
   output logic                        bus_mode_16,
   output logic                        port4_is_io
);
   // Initialisation sequence and pin synchronisers
   cfg_state_t        state_reg, state_next;
   logic [1:0]        mode_meta_reg;
   logic [1:0]        mode_sync_reg;
   logic [1:0]        mode_reg, mode_next;
   logic              stby_meta_reg;
   logic              stby_sync_reg;

   // Configuration registers and bus mode
   logic [7:0]        width_reg, width_next;
   logic [7:0]        states_reg, states_next;
   logic [7:0]        wait_hi_reg, wait_hi_next;
   logic [7:0]        wait_lo_reg, wait_lo_next;
   logic              bus16_reg, bus16_next;
   logic              port4_reg, port4_next;

   // Attributes of the current access
   logic              cyc_valid_reg, cyc_valid_next;
   logic              cyc_wide_reg, cyc_wide_next;
   logic [2:0]        cyc_states_reg, cyc_states_next;
   logic [1:0]        cyc_waits_reg, cyc_waits_next;

   // Register bus side band
   logic              wr_en;
   logic              wr_strb;
   logic              wr_ok;
   logic              rd_ok;
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0]        wr_data;
   logic [7:0]        rd_word;

   // Area lookup
   logic              area_narrow;
   logic              area_three;
   logic [1:0]        area_wait;
   logic              boot_wide;

   // Every output is a register, so no logic sits behind a pin
   assign cyc_valid   = cyc_valid_reg;
   assign cyc_wide    = cyc_wide_reg;
   assign cyc_states  = cyc_states_reg;
   assign cyc_waits   = cyc_waits_reg;
   assign bus_mode_16 = bus16_reg;
   assign port4_is_io = port4_reg;

   // ==========================================================================
   // Register bus slave
   axil_cfg_slave u_slave (
      .clk     (clk),
      .nrst    (nrst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),

      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      // Register side
      .wr_en   (wr_en),
      .wr_strb (wr_strb),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_ok   (wr_ok),
      .rd_word (rd_word),
      .rd_ok   (rd_ok)
   );

   // Writes are refused while the registers are held at their initial values
   always_comb begin
      wr_ok = 1'b0;

      // Only the four configuration words take writes
      if (state_reg == ST_RUN) begin
         case (wr_addr)
            OFS_AREA_BUS_WIDTH,
            OFS_AREA_ACCESS_STATES,
            OFS_WAIT_UPPER_AREAS,
            OFS_WAIT_LOWER_AREAS: wr_ok = 1'b1;
            default:              wr_ok = 1'b0;
         endcase
      end
   end

   always_comb begin
      rd_ok   = 1'b1;
      rd_word = 8'h00;

      // Reads are served in every state, so the status can be polled
      case (araddr)
         OFS_AREA_BUS_WIDTH:     rd_word = width_reg;
         OFS_AREA_ACCESS_STATES: rd_word = states_reg;
         OFS_WAIT_UPPER_AREAS:   rd_word = wait_hi_reg;
         OFS_WAIT_LOWER_AREAS:   rd_word = wait_lo_reg;
         OFS_STATUS: begin
            // Read-only view of the bus mode and the sequence
            rd_word[STAT_BUS16_BIT]                = bus16_reg;
            rd_word[STAT_RUN_BIT]                  = (state_reg == ST_RUN);
            rd_word[STAT_SWSTBY_BIT]               = sw_standby;
            rd_word[STAT_MODE_LSB +: 2]            = mode_reg;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   // ==========================================================================
   // Pin synchronisers and initialisation sequence
   // The mode strap is only trusted once it has passed both flops after reset release
   always_comb begin
      state_next = state_reg;
      mode_next  = mode_reg;

      case (state_reg)
         // Two idle edges let the strap pass both synchroniser flops
         ST_SYNC0: state_next = ST_SYNC1;
         ST_SYNC1: state_next = ST_HOLD;
         ST_HOLD: begin
            // Re-sampled on each pass, so a standby exit may change mode
            mode_next = mode_sync_reg;
            if (!stby_sync_reg) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stby_sync_reg) begin
               state_next = ST_HOLD;
            end
         end
         default: state_next = ST_SYNC0;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Standby reads as asserted until the pin is sampled
         state_reg     <= ST_SYNC0;
         mode_meta_reg <= MODE_1;
         mode_sync_reg <= MODE_1;
         mode_reg      <= MODE_1;
         stby_meta_reg <= 1'b1;
         stby_sync_reg <= 1'b1;
      end else begin
         state_reg     <= state_next;
         mode_meta_reg <= mode_pins;
         mode_sync_reg <= mode_meta_reg;
         mode_reg      <= mode_next;
         // Inverted here so the synchronised level is active high
         stby_meta_reg <= !hw_standby_n;
         stby_sync_reg <= stby_meta_reg;
      end
   end

   // ==========================================================================
   // Configuration registers
   // Modes 2 and 4 boot with all areas wide
   assign boot_wide = (mode_sync_reg == MODE_2) || (mode_sync_reg == MODE_4);

   // Software standby is deliberately absent here, so the contents survive it
   always_comb begin
      width_next   = width_reg;
      states_next  = states_reg;
      wait_hi_next = wait_hi_reg;
      wait_lo_next = wait_lo_reg;

      if (state_reg == ST_HOLD) begin
         width_next   = boot_wide ? RST_WIDTH_WIDE
                                  : RST_WIDTH_NARROW;
         states_next  = RST_ACCESS_STATES;
         wait_hi_next = RST_WAIT;
         wait_lo_next = RST_WAIT;
      end else if (wr_en && wr_strb) begin
         case (wr_addr)
            OFS_AREA_BUS_WIDTH:     width_next   = wr_data;
            OFS_AREA_ACCESS_STATES: states_next  = wr_data;
            OFS_WAIT_UPPER_AREAS:   wait_hi_next = wr_data;
            OFS_WAIT_LOWER_AREAS:   wait_lo_next = wr_data;
            default:                width_next   = width_reg;
         endcase
      end

      // Taken from the next value so the mode flag never lags
      bus16_next = (width_next != ALL_AREAS_NARROW);
      port4_next = (width_next == ALL_AREAS_NARROW);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Narrow until the strap has been read
         width_reg   <= RST_WIDTH_NARROW;
         states_reg  <= RST_ACCESS_STATES;
         wait_hi_reg <= RST_WAIT;
         wait_lo_reg <= RST_WAIT;
         bus16_reg   <= 1'b0;
         port4_reg   <= 1'b1;
      end else begin
         width_reg   <= width_next;
         states_reg  <= states_next;
         wait_hi_reg <= wait_hi_next;
         wait_lo_reg <= wait_lo_next;
         bus16_reg   <= bus16_next;
         port4_reg   <= port4_next;
      end
   end

   // ==========================================================================
   // Access attributes
   // Decoding is combinational; the answer is registered below
   area_attr_lookup #(
      .N_AREAS (N_AREAS),
      .AREA_W  (AREA_W)
   ) u_lookup (
      .width_bits  (width_reg),
      .three_bits  (states_reg),
      .wait_upper  (wait_hi_reg),
      .wait_lower  (wait_lo_reg),

      .area        (ext_area),
      .narrow      (area_narrow),
      .three_state (area_three),
      .wait_field  (area_wait)
   );

   // Attributes are latched at the start, so a write landing mid-cycle cannot disturb it
   always_comb begin
      cyc_valid_next  = ext_start;
      cyc_wide_next   = cyc_wide_reg;
      cyc_states_next = cyc_states_reg;
      cyc_waits_next  = cyc_waits_reg;

      if (ext_start) begin
         if (ext_onchip) begin
            // On-chip targets ignore all four registers
            cyc_wide_next   = ONCHIP_WIDE;
            cyc_states_next = ONCHIP_STATES;
            cyc_waits_next  = ONCHIP_WAITS;
         end else begin
            // Waits count only for three-state areas
            cyc_wide_next   = !area_narrow;
            cyc_states_next = area_three ? STATES_THREE : STATES_TWO;
            cyc_waits_next  = area_three ? area_wait : 2'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Idle attributes show the slowest external timing
         cyc_valid_reg  <= 1'b0;
         cyc_wide_reg   <= 1'b0;
         cyc_states_reg <= STATES_THREE;
         cyc_waits_reg  <= 2'h3;
      end else begin
         cyc_valid_reg  <= cyc_valid_next;
         cyc_wide_reg   <= cyc_wide_next;
         cyc_states_reg <= cyc_states_next;
         cyc_waits_reg  <= cyc_waits_next;
      end
   end

endmodule

`default_nettype wire

// ==== dv/external_area_bus_config_checker.sv ====
// Concurrent checks on the access-attribute ports of the bus configuration block
`default_nettype none
module external_area_bus_config_checker (
   // Clock and reset
   input wire logic       clk,
   input wire logic       nrst,
   // Access request and answer
   input wire logic       ext_start,
   input wire logic       ext_onchip,
   input wire logic       cyc_valid,
   input wire logic       cyc_wide,
   input wire logic [2:0] cyc_states,
   input wire logic [1:0] cyc_waits,
   // Bus mode
   input wire logic       bus_mode_16,
   input wire logic       port4_is_io
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // ====================
   // Assertions
   property p_start; ext_start |=> cyc_valid; endproperty
   a_start: assert property (p_start) else $error("no answer to access");
   property p_quiet; !ext_start |=> !cyc_valid; endproperty
   a_quiet: assert property (p_quiet) else $error("stray answer");
   property p_onchip; ext_start && ext_onchip |=> cyc_wide && cyc_states == 3'h2; endproperty
   a_onchip: assert property (p_onchip) else $error("on-chip timing");
   property p_states; ext_start && !ext_onchip |=> cyc_states inside {3'h2, 3'h3}; endproperty
   a_states: assert property (p_states) else $error("bad state count");
   property p_nowait; ##1 cyc_valid && cyc_states == 3'h2 |-> cyc_waits == 2'h0; endproperty
   a_nowait: assert property (p_nowait) else $error("waits on short cycle");
   property p_mode; bus_mode_16 != port4_is_io; endproperty
   a_mode: assert property (p_mode) else $error("bus mode mismatch");
   property p_hold; !ext_start |=> $stable({cyc_wide, cyc_states, cyc_waits}); endproperty
   a_hold: assert property (p_hold) else $error("attributes moved");
   property p_rst; $rose(nrst) |-> port4_is_io && !bus_mode_16; endproperty
   a_rst: assert property (p_rst) else $error("not narrow after reset");
   c_onchip: cover property (ext_start && ext_onchip);
   c_three: cover property (cyc_valid && cyc_waits == 2'h3);
   c_bus16: cover property ($rose(bus_mode_16));
endmodule
bind external_area_bus_config external_area_bus_config_checker chk_u (.*);
`default_nettype wire

// ==== dv/ext_mem_model.sv ====
// Far-side memory model: measures each external access from its attributes
`default_nettype none
module ext_mem_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Attributes of the started access
   input  wire logic       cyc_valid,
   input  wire logic       cyc_wide,
   input  wire logic [2:0] cyc_states,
   input  wire logic [1:0] cyc_waits,
   // Length in states and bytes per transfer
   output logic [3:0]      len_reg,
   output logic [1:0]      bytes_reg
);
   // Sums waits blindly so a wait leaking into a short cycle shows up in the length
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         len_reg   <= 4'h0;
         bytes_reg <= 2'h0;
      end else if (cyc_valid) begin
         len_reg   <= {1'b0, cyc_states} + {2'h0, cyc_waits};
         bytes_reg <= cyc_wide ? 2'h2 : 2'h1;
      end
   end
endmodule
`default_nettype wire

// ==== dv/tb_external_area_bus_config.sv ====
// Self-checking bench for the external area bus configuration block
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb_external_area_bus_config import ext_bus_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0, nrst = 1'b0, hw_standby_n = 1'b1, sw_standby = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        ext_start = 1'b0, ext_onchip = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'hF, len_reg;
   logic [1:0]  mode_pins = MODE_1, bresp, rresp, cyc_waits, bytes_reg;
   logic [2:0]  ext_area = 3'h0, cyc_states;
   logic        awready, wready, bvalid, arready, rvalid, cyc_valid, cyc_wide;
   logic        bus_mode_16, port4_is_io;
   int          fail_count = 0, checks_done = 0;
   external_area_bus_config dut_u (.*);
   ext_mem_model mem_u (.*);
   initial forever #2.5 clk = ~clk;
   // ====================
   // Bus and access tasks
   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 40) begin fail_count++; close_out(); end
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask
   task automatic axr(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 40) begin fail_count++; close_out(); end
      rready <= 1'b0;
      `CHK({rresp, rdata}, {er, 24'h0, ed})
   endtask
   task automatic regs4(input logic [31:0] v);
      axr(OFS_AREA_BUS_WIDTH, v[31:24], RESP_OKAY);
      axr(OFS_AREA_ACCESS_STATES, v[23:16], RESP_OKAY);
      axr(OFS_WAIT_UPPER_AREAS, v[15:8], RESP_OKAY);
      axr(OFS_WAIT_LOWER_AREAS, v[7:0], RESP_OKAY);
   endtask
   task automatic acc(input logic [3:0] a, input logic w, input logic [2:0] s, input logic [1:0] t);
      @(posedge clk);
      ext_area <= a[2:0];
      ext_onchip <= a[3];
      ext_start <= 1'b1;
      @(posedge clk);
      ext_start <= 1'b0;
      #1;
      `CHK({cyc_valid, cyc_wide, cyc_states, cyc_waits}, {1'b1, w, s, t})
      @(posedge clk);
      #1;
      `CHK({bytes_reg, len_reg}, {w ? 2'h2 : 2'h1, {1'b0, s} + {2'h0, t}})
   endtask
   // ====================
   // Scenarios
   task automatic t_reset;
      repeat (8) @(posedge clk);
      regs4(32'hFFFFFFFF);
      `CHK({bus_mode_16, port4_is_io}, 2'b01)
      axr(8'h14, 8'h00, RESP_SLVERR);
      axw(OFS_STATUS, 8'h00, RESP_SLVERR);
      $display("test reset done");
   endtask
   task automatic t_width;
      axw(OFS_AREA_BUS_WIDTH, 8'h7F, RESP_OKAY);
      `CHK({bus_mode_16, port4_is_io}, 2'b10)
      acc(4'h7, 1'b1, 3'h3, 2'h3);
      acc(4'h6, 1'b0, 3'h3, 2'h3);
      acc(4'hE, 1'b1, 3'h2, 2'h0);
      axw(OFS_AREA_BUS_WIDTH, 8'hFF, RESP_OKAY);
      `CHK({bus_mode_16, port4_is_io}, 2'b01)
      $display("test width done");
   endtask
   task automatic t_wait;
      axw(OFS_WAIT_LOWER_AREAS, 8'hE4, RESP_OKAY);
      axw(OFS_WAIT_UPPER_AREAS, 8'h1B, RESP_OKAY);
      for (int a = 0; a < 8; a++)
         acc(4'(a), 1'b0, 3'h3, (a < 4) ? 2'(a) : 2'(7 - a));
      axw(OFS_AREA_ACCESS_STATES, 8'hDF, RESP_OKAY);
      acc(4'h5, 1'b0, 3'h2, 2'h0);
      acc(4'h4, 1'b0, 3'h3, 2'h3);
      $display("test wait done");
   endtask
   task automatic t_standby;
      @(posedge clk);
      sw_standby <= 1'b1;
      regs4(32'hFFDF1BE4);
      sw_standby <= 1'b0;
      mode_pins <= MODE_2;
      hw_standby_n <= 1'b0;
      repeat (6) @(posedge clk);
      hw_standby_n <= 1'b1;
      repeat (10) @(posedge clk);
      regs4(32'h00FFFFFF);
      `CHK({bus_mode_16, port4_is_io}, 2'b10)
      acc(4'h2, 1'b1, 3'h3, 2'h3);
      $display("test standby done");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_width();
      t_wait();
      t_standby();
      close_out();
   end
endmodule
`default_nettype wire
